//--- msla_pkg.sv
// Constants, types and register maps for the multiframe sync controller.
// Assumes a single core clock; shared by the controller and its bench.
package msla_pkg;

  // ----------------------------------------------------------------
  // Device register map (reached over the device register port)
  // ----------------------------------------------------------------
  localparam logic [11:0] DEV_SKIP_ADDR = 12'h036; // Edge skip count
  localparam logic [11:0] DEV_WIN_ADDR = 12'h039; // Error window
  localparam logic [11:0] DEV_ONESHOT_ADDR = 12'h03A; // One-shot control
  localparam logic [11:0] DEV_ENABLE_ADDR = 12'h03B; // Align circuit enable
  localparam logic [11:0] DEV_OFFSET_ADDR = 12'h304; // Multiframe phase offset
  localparam logic [11:0] DEV_BUDGET_ADDR = 12'h306; // Arrival spread budget
  localparam logic [11:0] DEV_SUBCLASS_ADDR = 12'h458; // Link subclass select
  localparam logic [7:0] DEV_ENABLE_PLAIN = 8'hF1; // Enable, no ramp
  localparam logic [7:0] DEV_ENABLE_RAMP = 8'hF3; // Enable with sample ramp
  localparam logic [7:0] DEV_ONESHOT_CLEAR = 8'h00; // Drop earlier arming
  localparam logic [7:0] DEV_ONESHOT_ARM = 8'h02; // Arm one-shot
  localparam int DEV_DONE_BIT = 4; // Completion bit in one-shot control
  localparam int DEV_SUBCLASS_LSB = 5; // Subclass field bits [7:5]
  localparam logic [5:0] WIN_FIELD_MASK = 6'h3C; // Two low bits ignored
  localparam logic [5:0] WIN_MIN_CODE = 6'h04; // Four DAC clock tolerance
  localparam logic [7:0] BUDGET_MAX = 8'h0C; // Twelve processing clocks

  // ----------------------------------------------------------------
  // Own register map (AXI4-Lite byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00; // Start, ramp, subclass
  localparam logic [7:0] REG_WINDOW = 8'h04; // Error window code [5:0]
  localparam logic [7:0] REG_SKIP = 8'h08; // Edge skip count [7:0]
  localparam logic [7:0] REG_OFFSET = 8'h0C; // Multiframe phase offset
  localparam logic [7:0] REG_BUDGET = 8'h10; // Arrival spread budget
  localparam logic [7:0] REG_PCLKS = 8'h14; // Processing clocks per LMFC
  localparam logic [7:0] REG_STATUS = 8'h18; // Busy, done, links, drift
  localparam int CTRL_START = 0; // Write one to start
  localparam int CTRL_RAMP = 1; // Ramp samples around alignment
  localparam int CTRL_SUB1 = 2; // One selects subclass 1
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_LINKS_UP = 2;
  localparam int STAT_DRIFT = 3; // Sticky, write one to clear
  localparam logic [7:0] RST_PCLKS = 8'h08; // Reset processing clocks per LMFC
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Timing of the generated reference pulses
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50; // 20 MHz core clock
  localparam int SREF_HIGH_NS = 200; // Least high time of a pulse
  localparam int SREF_LOW_NS = 400; // Least low time between pulses
  localparam int SREF_HIGH_CYC = (SREF_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SREF_LOW_CYC = (SREF_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SREF_PER_CYC = SREF_HIGH_CYC + SREF_LOW_CYC;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr; // Device register address
    logic [7:0] wdata; // Write data
    logic wr; // Write request, held until acknowledged
    logic rd; // Read request, held until acknowledged
  } msla_dev_req_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_SYSREF,
    ST_POLL,
    ST_LINKS
  } msla_state_e;

endpackage

//--- msla_sync_ctrl.sv
// Controller that brings a receive link's multiframe clock into alignment.
// Assumes a device register port with a one-cycle ack, and AXI4-Lite software.
`timescale 1ns/1ps

module msla_sync_ctrl
  import msla_pkg::*;
#(
  parameter int NUM_LINKS = 2 // Sync request outputs watched
) (
  input wire logic core_clk, // 20 MHz core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output msla_dev_req_s dev_req, // Device register request
  input wire logic dev_ack, // Device access done, one cycle
  input wire logic [7:0] dev_rdata, // Device read data, valid with ack
  output logic sysref_out, // Generated reference pulses
  input wire logic [NUM_LINKS-1:0] link_sync_request_out, // Device sync requests
  input wire logic ref_edge_drift_flag // Device drift indication
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_LINKS < 1 || NUM_LINKS > 8) begin : g_chk
    $error("NUM_LINKS must lie between 1 and 8");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] awaddr_q; // Held write address
  logic aw_have_q; // Write address taken
  logic [31:0] wdata_q; // Held write data
  logic [3:0] wstrb_q; // Held write strobes
  logic w_have_q; // Write data taken
  logic bvalid_q; // Write response pending
  logic [1:0] bresp_q; // Write response code
  logic rvalid_q; // Read data pending
  logic [31:0] rdata_q; // Read data
  logic [1:0] rresp_q; // Read response code
  logic wr_fire; // Register write this cycle
  logic wr_low; // Low byte lane enabled
  logic ar_fire; // Read address taken
  logic [2:0] ctrl_q; // Subclass, ramp, start bit held at zero
  logic [5:0] win_q; // Error window code
  logic [7:0] skip_q; // Edge skip count
  logic [7:0] offset_q; // Multiframe phase offset
  logic [7:0] budget_q; // Arrival spread budget
  logic [7:0] pclks_q; // Processing clocks per LMFC
  logic start_req; // Software start pulse
  logic drift_q; // Sticky drift status
  logic drift_clr; // Software clears drift
  msla_state_e state_q; // Sequencer state
  logic [2:0] step_q; // Write step index
  msla_dev_req_s req_q; // Outstanding device request
  logic [3:0] cnt_q; // Pulse period counter
  logic [8:0] pulses_q; // Reference pulses sent
  logic sysref_q; // Reference output flop
  logic done_q; // Last sequence completed
  logic links_up; // All sync requests released
  logic [5:0] win_eff; // Window after clamping
  logic [7:0] pclks_eff; // Clocks per LMFC, at least one
  logic [7:0] offset_eff; // Offset after clamping
  logic [7:0] budget_lim; // Smaller of twelve and clocks per LMFC
  logic [7:0] budget_eff; // Budget after clamping
  logic [8:0] pulse_target; // Pulses needed to pass the skip count
  msla_dev_req_s step_req; // Request of the current step
  logic last_step; // Current step is the arm write

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_low = wstrb_q[0];

  // Address and data may arrive in either order
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      awaddr_q <= 8'h00;
      aw_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        // Unmapped or misaligned words answer with a slave error
        case (awaddr_q)
          REG_CTRL, REG_WINDOW, REG_SKIP, REG_OFFSET,
          REG_BUDGET, REG_PCLKS, REG_STATUS: bresp_q <= RESP_OKAY;
          default: bresp_q <= RESP_SLVERR;
        endcase
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // One cycle from address to data
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: rdata_q <= {29'h0000_0000, ctrl_q[2:1], 1'b0};
        REG_WINDOW: rdata_q <= {26'h000_0000, win_q};
        REG_SKIP: rdata_q <= {24'h00_0000, skip_q};
        REG_OFFSET: rdata_q <= {24'h00_0000, offset_q};
        REG_BUDGET: rdata_q <= {24'h00_0000, budget_q};
        REG_PCLKS: rdata_q <= {24'h00_0000, pclks_q};
        REG_STATUS: rdata_q <= {28'h000_0000, drift_q, links_up, done_q,
                                state_q != ST_IDLE};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  assign start_req = wr_fire && wr_low && awaddr_q == REG_CTRL && wdata_q[CTRL_START];
  assign drift_clr = wr_fire && wr_low && awaddr_q == REG_STATUS && wdata_q[STAT_DRIFT];

  // Low byte lane carries every field
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q <= 3'b000;
      win_q <= WIN_MIN_CODE;
      skip_q <= 8'h00;
      offset_q <= 8'h00;
      budget_q <= BUDGET_MAX;
      pclks_q <= RST_PCLKS;
    end else if (wr_fire && wr_low) begin
      case (awaddr_q)
        REG_CTRL: ctrl_q <= {wdata_q[CTRL_SUB1], wdata_q[CTRL_RAMP], 1'b0};
        REG_WINDOW: win_q <= wdata_q[5:0];
        REG_SKIP: skip_q <= wdata_q[7:0];
        REG_OFFSET: offset_q <= wdata_q[7:0];
        REG_BUDGET: budget_q <= wdata_q[7:0];
        REG_PCLKS: pclks_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clamping of values sent to the device
  // ----------------------------------------------------------------
  // Low two bits are meaningless, and below four cycles is too tight
  assign win_eff = ((win_q & WIN_FIELD_MASK) < WIN_MIN_CODE) ? WIN_MIN_CODE
                 : (win_q & WIN_FIELD_MASK);
  assign pclks_eff = (pclks_q == 8'h00) ? 8'h01 : pclks_q;
  assign offset_eff = (offset_q >= pclks_eff) ? pclks_eff - 8'h01 : offset_q;
  assign budget_lim = (pclks_eff < BUDGET_MAX) ? pclks_eff : BUDGET_MAX;
  assign budget_eff = (budget_q > budget_lim) ? budget_lim : budget_q;
  assign pulse_target = {1'b0, skip_q} + 9'h001;
  assign links_up = &link_sync_request_out;

  // ----------------------------------------------------------------
  // Step table of device writes
  // ----------------------------------------------------------------
  always_comb begin
    step_req = '0;
    step_req.wr = 1'b1;
    last_step = 1'b0;
    case (step_q)
      3'd0: begin
        step_req.addr = DEV_ENABLE_ADDR;
        step_req.wdata = ctrl_q[1] ? DEV_ENABLE_RAMP : DEV_ENABLE_PLAIN;
      end
      3'd1: begin
        step_req.addr = DEV_WIN_ADDR;
        step_req.wdata = {2'b00, win_eff};
      end
      3'd2: begin
        step_req.addr = DEV_SKIP_ADDR;
        step_req.wdata = skip_q;
      end
      3'd3: begin
        step_req.addr = DEV_OFFSET_ADDR;
        step_req.wdata = offset_eff;
      end
      3'd4: begin
        step_req.addr = DEV_BUDGET_ADDR;
        step_req.wdata = budget_eff;
      end
      3'd5: begin
        step_req.addr = DEV_SUBCLASS_ADDR;
        step_req.wdata = {2'b00, ctrl_q[2], 5'h00};
      end
      3'd6: begin
        step_req.addr = DEV_ONESHOT_ADDR;
        step_req.wdata = DEV_ONESHOT_CLEAR;
      end
      default: begin
        step_req.addr = DEV_ONESHOT_ADDR;
        step_req.wdata = DEV_ONESHOT_ARM;
        last_step = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Alignment sequencer
  // ----------------------------------------------------------------
  assign dev_req = req_q;
  assign sysref_out = sysref_q;

  // Writes, reference pulses in subclass 1 only, completion poll, then wait for links
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      step_q <= 3'd0;
      req_q <= '0;
      cnt_q <= 4'h0;
      pulses_q <= 9'h000;
      sysref_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_req) begin
            state_q <= ST_WRITE;
            step_q <= 3'd0;
            done_q <= 1'b0;
          end
        end
        ST_WRITE: begin
          if (!req_q.wr) begin
            req_q <= step_req;
          end else if (dev_ack) begin
            req_q <= '0;
            if (last_step) begin
              // Subclass 0 aligns on an internal edge, no pulses needed
              state_q <= ctrl_q[2] ? ST_SYSREF : ST_POLL;
              cnt_q <= 4'h0;
              pulses_q <= 9'h000;
            end else if (step_q == 3'd0 && !ctrl_q[2]) begin
              step_q <= 3'd3; // Window and skip only matter in subclass 1
            end else begin
              step_q <= step_q + 3'd1;
            end
          end
        end
        ST_SYSREF: begin
          // Skipped edges plus the aligning one, each a full pulse
          if (pulses_q == pulse_target) begin
            state_q <= ST_POLL;
          end else begin
            sysref_q <= cnt_q < 4'(SREF_HIGH_CYC);
            if (cnt_q == 4'(SREF_PER_CYC - 1)) begin
              cnt_q <= 4'h0;
              pulses_q <= pulses_q + 9'h001;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        ST_POLL: begin
          if (!req_q.rd) begin
            req_q <= '{addr: DEV_ONESHOT_ADDR, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
          end else if (dev_ack) begin
            req_q <= '0;
            if (dev_rdata[DEV_DONE_BIT]) begin
              state_q <= ST_LINKS;
            end
          end
        end
        ST_LINKS: begin
          // Links come back only after the rotation has finished
          if (links_up) begin
            state_q <= ST_IDLE;
            done_q <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Drift status
  // ----------------------------------------------------------------
  // A new drift event wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      drift_q <= 1'b0;
    end else if (ref_edge_drift_flag) begin
      drift_q <= 1'b1;
    end else if (drift_clr) begin
      drift_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic win_sent_q; // Window written this sequence
  logic skip_sent_q; // Skip count written this sequence
  logic clr_sent_q; // Clear written before arming
  logic dev_wr_take; // Device write acknowledged
  logic sref_seen_q; // Reference output one cycle late
  logic [8:0] rises_q; // Reference pulses driven on the pin

  assign dev_wr_take = req_q.wr && dev_ack;

  // Helper record of the write order
  always_ff @(posedge core_clk) begin
    // A start while busy is ignored by the sequencer, so it keeps the record
    if (!rst_n || (start_req && state_q == ST_IDLE)) begin
      win_sent_q <= 1'b0;
      skip_sent_q <= 1'b0;
      clr_sent_q <= 1'b0;
      sref_seen_q <= 1'b0;
      rises_q <= 9'h000;
    end else begin
      sref_seen_q <= sysref_out;
      // Pulses counted on the pin, independent of the sequencer's own count
      if (sysref_out && !sref_seen_q) begin
        rises_q <= rises_q + 9'h001;
      end
      if (dev_wr_take) begin
        if (req_q.addr == DEV_WIN_ADDR) win_sent_q <= 1'b1;
        if (req_q.addr == DEV_SKIP_ADDR) skip_sent_q <= 1'b1;
        if (req_q.addr == DEV_ONESHOT_ADDR) clr_sent_q <= req_q.wdata == DEV_ONESHOT_CLEAR;
      end
    end
  end

  sequence sref_pulse_s;
    sysref_out [*4] ##1 !sysref_out;
  endsequence

  win_floor_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_q.wr && req_q.addr == DEV_WIN_ADDR |-> req_q.wdata[5:0] >= WIN_MIN_CODE
                                           && req_q.wdata[1:0] == 2'b00)
    else $error("window code below four cycles or low bits set");

  enable_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_q.wr && req_q.addr == DEV_ENABLE_ADDR |->
      req_q.wdata == (ctrl_q[1] ? DEV_ENABLE_RAMP : DEV_ENABLE_PLAIN))
    else $error("enable code wrong");

  cfg_before_arm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_q.wr && req_q.wdata == DEV_ONESHOT_ARM && req_q.addr == DEV_ONESHOT_ADDR
      && ctrl_q[2] |-> win_sent_q && skip_sent_q)
    else $error("armed before window and skip count were written");

  clear_then_arm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_q.wr && req_q.wdata == DEV_ONESHOT_ARM && req_q.addr == DEV_ONESHOT_ADDR
      |-> clr_sent_q)
    else $error("armed without clearing first");

  edge_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == ST_SYSREF ##1 state_q == ST_POLL |-> rises_q == pulse_target)
    else $error("wrong number of reference pulses");

  pulse_width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(sysref_out) |-> sref_pulse_s)
    else $error("reference pulse not four cycles wide");

  offset_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_q.wr && req_q.addr == DEV_OFFSET_ADDR |-> req_q.wdata < pclks_eff)
    else $error("offset not below clocks per multiframe");

  budget_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_q.wr && req_q.addr == DEV_BUDGET_ADDR |->
      req_q.wdata <= BUDGET_MAX && req_q.wdata <= pclks_eff)
    else $error("budget above limit");

  same_values_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == ST_WRITE && step_q == 3'd3 && req_q.wr |-> req_q.wdata == offset_eff)
    else $error("offset differs from programmed value");

  done_after_links_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == ST_LINKS && links_up |=> done_q && state_q == ST_IDLE)
    else $error("completion not reported after links released");

endmodule

//--- msla_dev_model.sv
// Behavioural device: register space, counted-edge alignment, drift flag.
// Assumes requests are held until the one-cycle ack, as the controller does.
`timescale 1ns/1ps
module msla_dev_model
  import msla_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic rst_n, // Reset, active low
  input msla_dev_req_s dev_req, // Register request
  output logic dev_ack, // One-cycle ack
  output logic [7:0] dev_rdata, // Read data
  input wire logic sysref_in, // Reference pulses
  input wire logic drift_cmd, // Bench orders an out-of-window edge
  output logic [1:0] link_sync_request_out, // Sync requests
  output logic ref_edge_drift_flag // Drift flag
);
  // ----
  // State
  // ----
  logic [7:0] regs [0:4095]; // Register space
  logic [1:0] wait_q; // Ack delay, slow on purpose
  logic sref_q; // Last reference level
  logic armed_q; // One-shot armed
  logic [7:0] seen_q; // Edges skipped so far
  int n_edges; // All reference edges seen
  wire rise = sysref_in & !sref_q;
  // Inverse data outside the ack so a stale value never matches
  assign dev_rdata = dev_ack ? regs[dev_req.addr] : ~regs[dev_req.addr];
  // Access, arming and rotation
  always_ff @(posedge core_clk) begin
    sref_q <= sysref_in;
    ref_edge_drift_flag <= drift_cmd;
    if (!rst_n) begin
      dev_ack <= 1'b0;
      wait_q <= 2'd0;
      armed_q <= 1'b0;
      n_edges <= 0;
      regs[DEV_ONESHOT_ADDR] <= 8'h00;
      link_sync_request_out <= '1;
    end else begin
      n_edges <= n_edges + int'(rise);
      dev_ack <= 1'b0;
      if ((dev_req.wr | dev_req.rd) && !dev_ack) begin
        wait_q <= wait_q + 2'd1;
        if (wait_q == 2'd2) begin
          dev_ack <= 1'b1;
          wait_q <= 2'd0;
          if (dev_req.wr) regs[dev_req.addr] <= dev_req.wdata;
          if (dev_req.wr && dev_req.addr == DEV_ONESHOT_ADDR && dev_req.wdata == DEV_ONESHOT_ARM) begin
            armed_q <= 1'b1;
            seen_q <= 8'h00;
            link_sync_request_out <= '0;
          end
        end
      end
      // Subclass 0 aligns at once, subclass 1 after the skipped edges
      if (armed_q && (regs[DEV_SUBCLASS_ADDR][7:5] == 3'd0 || (rise && seen_q == regs[DEV_SKIP_ADDR]))) begin
        armed_q <= 1'b0;
        regs[DEV_ONESHOT_ADDR][DEV_DONE_BIT] <= 1'b1;
        link_sync_request_out <= '1;
      end else if (armed_q && rise) seen_q <= seen_q + 8'h01;
    end
  end
endmodule

//--- test_msla_sync_ctrl.sv
// Self-checking bench for the sync controller against the device model.
// Assumes default NUM_LINKS of two.
`timescale 1ns/1ps
module test_msla_sync_ctrl;
  import msla_pkg::*;
  logic core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, drift_cmd;
  logic awready, wready, bvalid, arready, rvalid, dev_ack, sysref_out, drift;
  logic [7:0] awaddr, araddr, dev_rdata;
  logic [31:0] wdata, rdata, rd_q;
  logic [1:0] bresp, rresp, resp_q, links;
  msla_dev_req_s dev_req;
  int bad_count, num_checks, cycles, links_low, lows;
  logic [3:0] wstrb;
  msla_sync_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dev_req(dev_req),
    .dev_ack(dev_ack), .dev_rdata(dev_rdata), .sysref_out(sysref_out),
    .link_sync_request_out(links), .ref_edge_drift_flag(drift));
  msla_dev_model m (.core_clk(core_clk), .rst_n(rst_n), .dev_req(dev_req), .dev_ack(dev_ack),
    .dev_rdata(dev_rdata), .sysref_in(sysref_out), .drift_cmd(drift_cmd),
    .link_sync_request_out(links), .ref_edge_drift_flag(drift));
  // ----
  // Bus tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Each channel released only at the edge that takes it
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(awvalid === 1'b0 || awready) || !(wvalid === 1'b0 || wready));
    bready <= 1'b1;
    do @(posedge core_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp_q = bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_q = rdata;
    resp_q = rresp;
  endtask
  // Start a sequence and poll until it leaves busy
  task automatic run_sync(input logic [31:0] ctrl);
    int n;
    n = 0;
    axw(REG_CTRL, ctrl);
    do begin
      axr(REG_STATUS);
      n++;
    end while (rd_q[STAT_BUSY] !== 1'b0 && n < 300);
    chk(rd_q, 32'h0000_0006);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Watchdog against a hang
  always @(posedge core_clk) begin
    cycles++;
    if (links != 2'b11) links_low++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, drift_cmd} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    axr(REG_WINDOW);
    chk(rd_q, 32'h0000_0004);
    axr(REG_BUDGET);
    chk(rd_q, 32'h0000_000C);
    axr(8'h1C);
    chk(32'(resp_q), 32'(RESP_SLVERR));
    axw(8'h1C, 32'h0000_0001);
    chk(32'(resp_q), 32'(RESP_SLVERR));
    // Low byte lane off: answered, but nothing lands
    wstrb <= 4'h0;
    axw(REG_SKIP, 32'h0000_0005);
    wstrb <= 4'hF;
    chk(32'(resp_q), 32'(RESP_OKAY));
    axr(REG_SKIP);
    chk(rd_q, 32'h0000_0000);
    // Subclass 1 with skip of three and out-of-range settings
    axw(REG_WINDOW, 32'h0000_0007);
    axw(REG_SKIP, 32'h0000_0003);
    axw(REG_OFFSET, 32'h0000_000A);
    axw(REG_BUDGET, 32'h0000_0020);
    run_sync(32'h0000_0007);
    chk(32'(m.regs[DEV_WIN_ADDR]), 32'h0000_0004);
    chk(32'(m.regs[DEV_SKIP_ADDR]), 32'h0000_0003);
    chk(32'(m.regs[DEV_OFFSET_ADDR]), 32'h0000_0007);
    chk(32'(m.regs[DEV_BUDGET_ADDR]), 32'h0000_0008);
    chk(32'(m.regs[DEV_ENABLE_ADDR]), 32'(DEV_ENABLE_RAMP));
    chk(32'(m.regs[DEV_SUBCLASS_ADDR]), 32'h0000_0020);
    chk(32'(m.n_edges), 32'h0000_0004);
    lows = links_low;
    chk(32'(lows > 0), 32'h0000_0001);
    // Drift is sticky until written one
    @(posedge core_clk);
    drift_cmd <= 1'b1;
    @(posedge core_clk);
    drift_cmd <= 1'b0;
    repeat (3) @(posedge core_clk);
    axr(REG_STATUS);
    chk(32'(rd_q[STAT_DRIFT]), 32'h0000_0001);
    axw(REG_STATUS, 32'h0000_0008);
    axr(REG_STATUS);
    chk(32'(rd_q[STAT_DRIFT]), 32'h0000_0000);
    chk(32'(m.regs[DEV_ONESHOT_ADDR][DEV_DONE_BIT]), 32'h0000_0001);
    // Subclass 0 needs no reference edges
    axw(REG_WINDOW, 32'h0000_001C);
    run_sync(32'h0000_0001);
    chk(32'(m.regs[DEV_SUBCLASS_ADDR]), 32'h0000_0000);
    chk(32'(m.regs[DEV_ENABLE_ADDR]), 32'(DEV_ENABLE_PLAIN));
    chk(32'(m.regs[DEV_WIN_ADDR]), 32'h0000_0004);
    chk(32'(m.n_edges), 32'h0000_0004);
    chk(32'(links_low > lows), 32'h0000_0001);
    results();
  end
endmodule
